// ===== rtl/atten_ctrl.v
// Serial control interface of a two-channel stepped attenuator
// Overview of operation
// RULE1 - Serial data enters the shift register on rising serial clock edges.
// RULE2 - Bits are taken only while the load strobe stays low.
// RULE3 - Older shift register bits leave one per shift on the chain output.
// RULE4 - The controller raises the strobe only after all chain bits.
// RULE5 - A latched word changes a channel only when its address is known.
// RULE6 - A recognized word sets that channel to the level its byte encodes.
// RULE7 - Each of the two channels keeps its own setting.
// RULE8 - A transfer is sixteen bits MSB first: address then level byte.
// RULE9 - Address zero selects the first channel, address one the second.
// RULE10 - Codes below 60h are half-dB, 60h-7Eh one-dB, 7Fh and up mute.
// RULE11 - After reset every channel is muted until a valid update.
// RULE12 - The strobe rising edge copies the word to a latch for decode.
`timescale 1ns/1ps
`include "atten_ctrl_regs.vh"
module atten_ctrl
(
  // Clock and reset
  input  wire       clk_i,
  input  wire       nrst_i,
  // Serial pins
  input  wire       sclk_i,
  input  wire       load_n_i,
  input  wire       sdata_i,
  output reg        sdata_o,
  // Channel settings
  output reg  [7:0] level_a_o,
  output reg  [7:0] level_b_o,
  output reg        mute_a_o,
  output reg        mute_b_o,
  output reg        coarse_a_o,
  output reg        coarse_b_o,
  output reg        update_o
);

  // ****************************************
  // Declarations
  // ****************************************
  reg  [1:0]  sclk_s_q;
  reg  [1:0]  load_s_q;
  reg  [1:0]  data_s_q;
  reg         sclk_q;
  reg         load_q;
  reg  [15:0] shift_q;
  reg  [15:0] hold_q;
  reg         hold_vld_q;
  wire        sclk_rise;
  wire        load_rise;
  wire        addr_ok;
  wire [7:0]  addr_fld;
  wire [7:0]  level_fld;
  wire        wr_en;
  wire        wr_sel;
  wire [7:0]  st_a;
  wire [7:0]  st_b;

  // ****************************************
  // Decode functions
  // ****************************************
  function mute_dec;
    input [7:0] code;
    begin
      mute_dec = (code >= `MUTE_CODE); // RULE10
    end
  endfunction

  function coarse_dec;
    input [7:0] code;
    begin
      coarse_dec = (code >= `HALF_STEP_END) && (code <= `FULL_STEP_END);
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sclk_s_q <= `SYNC_LOW;
      load_s_q <= `SYNC_HIGH;
      data_s_q <= `SYNC_LOW;
    end
    else
    begin
      sclk_s_q <= {sclk_s_q[0], sclk_i};
      load_s_q <= {load_s_q[0], load_n_i};
      data_s_q <= {data_s_q[0], sdata_i};
    end
  end

  // ****************************************
  // Edge detection
  // ****************************************
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sclk_q <= 1'b0;
      load_q <= 1'b1;
    end
    else
    begin
      sclk_q <= sclk_s_q[1];
      load_q <= load_s_q[1];
    end
  end

  assign sclk_rise = sclk_s_q[1] & ~sclk_q;
  assign load_rise = load_s_q[1] & ~load_q;

  // ****************************************
  // Shift register and chain output
  // ****************************************
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      shift_q <= `SHIFT_RESET;
      sdata_o <= 1'b0;
    end
    else if (sclk_rise && !load_s_q[1]) // RULE2
    begin
      shift_q <= {shift_q[`WORD_BITS-2:0], data_s_q[1]}; // RULE1 RULE8
      sdata_o <= shift_q[`WORD_BITS-1]; // RULE3
    end
  end

  // ****************************************
  // Holding latch and decode
  // ****************************************
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      hold_q     <= `SHIFT_RESET;
      hold_vld_q <= 1'b0;
    end
    else
    begin
      hold_vld_q <= load_rise;
      if (load_rise)
        hold_q <= shift_q; // RULE12
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  assign addr_fld  = hold_q[`ADDR_MSB:`ADDR_LSB]; // RULE8
  assign level_fld = hold_q[`LEVEL_MSB:`LEVEL_LSB]; // RULE8
  assign addr_ok   = (addr_fld == `CHAN_A_CODE) ||
                     (addr_fld == `CHAN_B_CODE); // RULE9
  assign wr_en     = hold_vld_q & addr_ok; // RULE5
  assign wr_sel    = hold_q[`ADDR_LSB]; // RULE9

  // ****************************************
  // Level store
  // ****************************************
  level_store u_store
  (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .wr_en_i   (wr_en), // RULE5
    .wr_sel_i  (wr_sel),
    .wr_data_i (level_fld), // RULE6
    .level_a_o (st_a),
    .level_b_o (st_b)
  );

  // ****************************************
  // Output registers
  // ****************************************
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      level_a_o  <= `MUTE_CODE;
      level_b_o  <= `MUTE_CODE;
      mute_a_o   <= 1'b1; // RULE11
      mute_b_o   <= 1'b1; // RULE11
      coarse_a_o <= 1'b0;
      coarse_b_o <= 1'b0;
      update_o   <= 1'b0;
    end
    else
    begin
      level_a_o  <= st_a;
      level_b_o  <= st_b;
      mute_a_o   <= mute_dec(st_a); // RULE10
      mute_b_o   <= mute_dec(st_b); // RULE10
      coarse_a_o <= coarse_dec(st_a); // RULE10
      coarse_b_o <= coarse_dec(st_b); // RULE10
      update_o   <= wr_en; // RULE12
    end
  end

endmodule // atten_ctrl

// ===== rtl/atten_ctrl_regs.vh
// Constants for the serial attenuator control block
`ifndef ATTEN_CTRL_REGS_VH
`define ATTEN_CTRL_REGS_VH
`define WORD_BITS      16
`define ADDR_MSB       15
`define ADDR_LSB       8
`define LEVEL_MSB      7
`define LEVEL_LSB      0
`define CHAN_A_CODE    8'h00
`define CHAN_B_CODE    8'h01
`define HALF_STEP_END  8'h60
`define FULL_STEP_END  8'h7E
`define MUTE_CODE      8'h7F
`define SHIFT_RESET    16'h0000
`define SYNC_LOW       2'h0
`define SYNC_HIGH      2'h3
`endif

// ===== rtl/level_store.v
// Two-entry attenuation level store with registered read data
`timescale 1ns/1ps
`include "atten_ctrl_regs.vh"
module level_store
(
  // Clock and reset
  input  wire       clk_i,
  input  wire       nrst_i,
  // Write port
  input  wire       wr_en_i,
  input  wire       wr_sel_i,
  input  wire [7:0] wr_data_i,
  // Read data
  output reg  [7:0] level_a_o,
  output reg  [7:0] level_b_o
);

  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      level_a_o <= `MUTE_CODE; // RULE11
      level_b_o <= `MUTE_CODE; // RULE11
    end
    else if (wr_en_i)
    begin
      if (wr_sel_i)
        level_b_o <= wr_data_i; // RULE7
      else
        level_a_o <= wr_data_i; // RULE7
    end
  end

endmodule // level_store

// ===== tb/atten_ctrl_sva.sv
// Assertions for the serial attenuator control block
`timescale 1ns/1ps
module atten_ctrl_sva
(
  input wire       clk_i, nrst_i, sclk_i, load_n_i, sdata_i, sdata_o,
  input wire [7:0] level_a_o, level_b_o,
  input wire       mute_a_o, mute_b_o, coarse_a_o, coarse_b_o, update_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_idle; load_n_i [*5]; endsequence
  a_mute_a_dec: assert property (mute_a_o == (level_a_o >= 8'h7F))
    else $error("mute a decode wrong");
  a_mute_b_dec: assert property (mute_b_o == (level_b_o >= 8'h7F))
    else $error("mute b decode wrong");
  a_coarse_a_dec: assert property (coarse_a_o ==
    (level_a_o >= 8'h60 && level_a_o <= 8'h7E)) else $error("coarse a wrong");
  a_coarse_b_dec: assert property (coarse_b_o ==
    (level_b_o >= 8'h60 && level_b_o <= 8'h7E)) else $error("coarse b wrong");
  a_level_cause: assert property (level_a_o != $past(level_a_o) |->
    update_o || $past(update_o)) else $error("level a moved alone");
  a_one_chan: assert property (!(level_a_o != $past(level_a_o) &&
    level_b_o != $past(level_b_o))) else $error("both channels moved");
  a_upd_pulse: assert property (update_o |=> !update_o)
    else $error("update too long");
  a_idle_hold: assert property (s_idle |-> $stable(sdata_o))
    else $error("shift while idle");
  a_reset_mute: assert property ($rose(nrst_i) |-> mute_a_o && mute_b_o)
    else $error("not muted after reset");
endmodule // atten_ctrl_sva
bind atten_ctrl atten_ctrl_sva u_sva (.clk_i(clk_i), .nrst_i(nrst_i),
  .sclk_i(sclk_i), .load_n_i(load_n_i), .sdata_i(sdata_i),
  .sdata_o(sdata_o), .level_a_o(level_a_o), .level_b_o(level_b_o),
  .mute_a_o(mute_a_o), .mute_b_o(mute_b_o), .coarse_a_o(coarse_a_o),
  .coarse_b_o(coarse_b_o), .update_o(update_o));

// ===== tb/mcu_drv.sv
// Controller model driving the three-wire serial line
`timescale 1ns/1ps
module mcu_drv
(
  input  wire clk_i,
  input  wire sdata_i,
  output reg  sclk_o = 1'b0,
  output reg  load_n_o = 1'b1,
  output reg  sdata_o = 1'b0
);
  reg [15:0] cap;
  integer    k;
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk_i);
      #1;
    end
  endtask
  task send(input [15:0] w);
    begin
      load_n_o = 1'b0;
      tick(4);
      for (k = 15; k >= 0; k = k - 1)
      begin
        sdata_o = w[k];
        tick(4);
        sclk_o = 1'b1;
        tick(4);
        sclk_o = 1'b0;
        tick(4);
        cap = {cap[14:0], sdata_i};
      end
      load_n_o = 1'b1;
      sdata_o = ~w[0];
      tick(12);
    end
  endtask
endmodule // mcu_drv

// ===== tb/testbench.sv
// Self-checking bench for the serial attenuator control block
`timescale 1ns/1ps
module testbench;
  reg        clk_i = 1'b0, nrst_i = 1'b0;
  wire       sclk, load_n, sdi, sdo, ma, mb, ca, cb, upd;
  wire [7:0] la, lb;
  integer    err_count = 0, checked = 0, seed = 42601, i, ea = 127, eb = 127;
  integer    upd_cnt = 0, exp_upd = 0;
  reg [15:0] w, prev = 16'h0000;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (upd === 1'b1) upd_cnt <= upd_cnt + 1;
  atten_ctrl u_atten_ctrl (.clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk),
    .load_n_i(load_n), .sdata_i(sdi), .sdata_o(sdo), .level_a_o(la),
    .level_b_o(lb), .mute_a_o(ma), .mute_b_o(mb), .coarse_a_o(ca),
    .coarse_b_o(cb), .update_o(upd));
  mcu_drv u_mcu (.clk_i(clk_i), .sdata_i(sdo), .sclk_o(sclk),
    .load_n_o(load_n), .sdata_o(sdi));
  function [9:0] dec(input integer v);
    dec = {v >= 96 && v <= 126, v >= 127, v[7:0]};
  endfunction
  task chk(input [19:0] got, input [19:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("errors=%0d checks=%0d", err_count, checked);
      if (err_count == 0 && checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    u_mcu.tick(1);
    chk({cb, mb, lb, ca, ma, la}, {dec(127), dec(127)});
    for (i = 0; i < 24; i = i + 1)
    begin
      w[15:8] = i % 3;
      w[7:0] = (i < 8) ? 8'h7C + i : $random(seed);
      u_mcu.send(w);
      chk(u_mcu.cap, prev);
      prev = w;
      if (w[15:8] == 8'h00) ea = w[7:0];
      if (w[15:8] == 8'h01) eb = w[7:0];
      if (w[15:8] <= 8'h01) exp_upd = exp_upd + 1;
      chk(upd_cnt[19:0], exp_upd[19:0]);
      chk({cb, mb, lb, ca, ma, la}, {dec(eb), dec(ea)});
    end
    final_report;
  end
  initial
  begin
    #400000;
    err_count = err_count + 1;
    final_report;
  end
endmodule // testbench
